// [design/lfct_timer.sv]
// Clock timer: 8-bit up-counter on a 256 Hz tick with interrupt causes, on APB.
//
// The APB register port was decided locally.
`timescale 1ns/100ps

module lfct_timer
  import lfct_pkg::*;
#(
  // System clock cycles per tick; a bench may shorten it to reach the counter quickly.
  parameter int TICK_CYCLES = LFCT_TICK_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  cpu_mask_level,
  output logic             irq_req,
  output logic      [1:0]  irq_level,
  output logic      [23:0] irq_vector
);

  logic [31:0]  tick_cnt_ff;
  logic         tick_fall;
  lfct_state_t  state_ff;
  lfct_state_t  nxt_state;
  logic         run_req_ff;
  logic [7:0]   count_ff;
  logic [7:0]   nxt_count;
  logic [3:0]   cause_ff;
  logic [3:0]   en_ff;
  logic [1:0]   prio_ff;
  logic [31:0]  prdata_ff;
  logic         pslverr_ff;
  logic         wr_access;
  logic         rd_access;
  logic         addr_hit;
  logic [3:0]   stage_fall;
  logic [3:0]   pending;
  logic [7:0]   wr_byte;

  // Byte lane of a register address within its aligned word.
  function automatic logic [1:0] lane_of(input logic [15:0] a);
    lane_of = a[1:0];
  endfunction

  // Byte of write data for a register address.
  function automatic logic [7:0] wbyte(input logic [15:0] a, input logic [31:0] d);
    wbyte = d[8 * lane_of(a) +: 8];
  endfunction

  // True when the current access targets register address a.
  function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
    hit = (p == a);
  endfunction

  // Write byte on the lane of the addressed register.
  assign wr_byte   = wbyte(paddr, pwdata);
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign addr_hit  = hit(LFCT_PRIO_ADDR, paddr) || hit(LFCT_EN_ADDR, paddr) ||
                     hit(LFCT_CAUSE_ADDR, paddr) || hit(LFCT_CTRL_ADDR, paddr) ||
                     hit(LFCT_COUNT_ADDR, paddr);

  // Divider making the 256 Hz tick; tick_fall marks its falling edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_ff <= 32'h00000000;
    end else if (tick_cnt_ff == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_ff <= 32'h00000000;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
    end
  end
  assign tick_fall = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

  // Software run request, held until the tick applies it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_req_ff <= 1'b0;
    end else if (wr_access && hit(LFCT_CTRL_ADDR, paddr) && pstrb[lane_of(paddr)]) begin
      run_req_ff <= wr_byte[LFCT_RUN_BIT];
    end
  end

  // Run state moves only on the tick's falling edge.
  always_comb begin
    nxt_state = state_ff;
    if (tick_fall) begin
      case (state_ff)
        LFCT_STOPPED:  nxt_state = run_req_ff ? LFCT_RUNNING : LFCT_STOPPED;
        LFCT_RUNNING:  nxt_state = run_req_ff ? LFCT_RUNNING : LFCT_STOPPED;
        LFCT_STOPPING: nxt_state = LFCT_STOPPED;
        default:       nxt_state = LFCT_STOPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= LFCT_STOPPED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Counter: increments on a tick fall while running (including the tick that stops it).
  always_comb begin
    nxt_count = count_ff;
    if (tick_fall && state_ff == LFCT_RUNNING) begin
      nxt_count = count_ff + 8'h01;
    end
    if (wr_access && hit(LFCT_CTRL_ADDR, paddr) && pstrb[lane_of(paddr)] &&
        wr_byte[LFCT_CLEAR_BIT]) begin
      nxt_count = LFCT_COUNT_RST;
    end
  end

  // Count register; bus writes to the count address never reach it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= LFCT_COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Falling edges of the tapped stages, seen as a one-to-zero change.
  always_comb begin
    stage_fall = 4'h0;
    stage_fall[LFCT_SRC_32HZ] = count_ff[LFCT_STG_32HZ] && !nxt_count[LFCT_STG_32HZ];
    stage_fall[LFCT_SRC_8HZ]  = count_ff[LFCT_STG_8HZ]  && !nxt_count[LFCT_STG_8HZ];
    stage_fall[LFCT_SRC_2HZ]  = count_ff[LFCT_STG_2HZ]  && !nxt_count[LFCT_STG_2HZ];
    stage_fall[LFCT_SRC_1HZ]  = count_ff[LFCT_STG_1HZ]  && !nxt_count[LFCT_STG_1HZ];
  end

  // Cause flags: an edge in the clearing cycle wins over the clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_ff <= LFCT_FLAG_RST;
    end else if (wr_access && hit(LFCT_CAUSE_ADDR, paddr) && pstrb[lane_of(paddr)]) begin
      cause_ff <= (cause_ff & ~wr_byte[3:0]) | stage_fall;
    end else begin
      cause_ff <= cause_ff | stage_fall;
    end
  end

  // Interrupt enables.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= LFCT_FLAG_RST;
    end else if (wr_access && hit(LFCT_EN_ADDR, paddr) && pstrb[lane_of(paddr)]) begin
      en_ff <= wr_byte[3:0];
    end
  end

  // Priority level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_ff <= LFCT_PRIO_RST;
    end else if (wr_access && hit(LFCT_PRIO_ADDR, paddr) && pstrb[lane_of(paddr)]) begin
      prio_ff <= wr_byte[1:0];
    end
  end

  // Interrupt request to the CPU and the vector of the highest-frequency pending source.
  assign pending = cause_ff & en_ff;
  always_comb begin
    irq_req    = (pending != 4'h0) && (prio_ff > cpu_mask_level);
    irq_level  = prio_ff;
    irq_vector = LFCT_VEC_1HZ;
    if (pending[LFCT_SRC_32HZ]) begin
      irq_vector = LFCT_VEC_32HZ;
    end else if (pending[LFCT_SRC_8HZ]) begin
      irq_vector = LFCT_VEC_8HZ;
    end else if (pending[LFCT_SRC_2HZ]) begin
      irq_vector = LFCT_VEC_2HZ;
    end
  end

  // Read data, captured in the setup phase; unmapped addresses answer with an error.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= !addr_hit;
      if (hit(LFCT_PRIO_ADDR, paddr)) begin
        prdata_ff[8 * lane_of(paddr) +: 8] <= {6'h00, prio_ff};
      end else if (hit(LFCT_EN_ADDR, paddr)) begin
        prdata_ff[8 * lane_of(paddr) +: 8] <= {4'h0, en_ff};
      end else if (hit(LFCT_CAUSE_ADDR, paddr)) begin
        prdata_ff[8 * lane_of(paddr) +: 8] <= {4'h0, cause_ff};
      end else if (hit(LFCT_CTRL_ADDR, paddr)) begin
        // Clear bit reads zero; run reads one until the counter has stopped.
        prdata_ff[8 * lane_of(paddr) +: 8] <=
          {7'h00, run_req_ff || state_ff != LFCT_STOPPED};
      end else if (hit(LFCT_COUNT_ADDR, paddr)) begin
        prdata_ff[8 * lane_of(paddr) +: 8] <= count_ff;
      end
    end
  end

  // One wait-free access phase: ready is high whenever the access phase is present.
  assign pready  = 1'b1;
  assign prdata  = rd_access ? prdata_ff : 32'h00000000;
  assign pslverr = psel && penable && pslverr_ff;

endmodule

// [design/lfct_pkg.sv]
// Package with register map, field positions and timing constants for the clock timer.
package lfct_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [15:0] LFCT_PRIO_ADDR  = 16'hff20;
  localparam logic [15:0] LFCT_EN_ADDR    = 16'hff22;
  localparam logic [15:0] LFCT_CAUSE_ADDR = 16'hff24;
  localparam logic [15:0] LFCT_CTRL_ADDR  = 16'hff40;
  localparam logic [15:0] LFCT_COUNT_ADDR = 16'hff41;

  // Field positions.
  localparam int LFCT_RUN_BIT   = 0;
  localparam int LFCT_CLEAR_BIT = 1;
  localparam int LFCT_SRC_1HZ   = 0;
  localparam int LFCT_SRC_2HZ   = 1;
  localparam int LFCT_SRC_8HZ   = 2;
  localparam int LFCT_SRC_32HZ  = 3;
  localparam int LFCT_STG_32HZ  = 2;
  localparam int LFCT_STG_8HZ   = 4;
  localparam int LFCT_STG_2HZ   = 6;
  localparam int LFCT_STG_1HZ   = 7;

  // Reset values.
  localparam logic [7:0] LFCT_COUNT_RST = 8'h00;
  localparam logic [3:0] LFCT_FLAG_RST  = 4'h0;
  localparam logic [1:0] LFCT_PRIO_RST  = 2'h0;

  // Exception vector addresses per source.
  localparam logic [23:0] LFCT_VEC_32HZ = 24'h00001c;
  localparam logic [23:0] LFCT_VEC_8HZ  = 24'h00001e;
  localparam logic [23:0] LFCT_VEC_2HZ  = 24'h000020;
  localparam logic [23:0] LFCT_VEC_1HZ  = 24'h000022;

  // Tick timing: the 256 Hz tick period in the 125 MHz system clock.
  localparam int LFCT_CLK_HZ      = 125000000;
  localparam int LFCT_TICK_HZ     = 256;
  localparam int LFCT_TICK_CYCLES = LFCT_CLK_HZ / LFCT_TICK_HZ;

  // Run state of the counter.
  typedef enum logic [1:0] {
    LFCT_STOPPED  = 2'b00,
    LFCT_RUNNING  = 2'b01,
    LFCT_STOPPING = 2'b10
  } lfct_state_t;

endpackage

// [tb/lfct_checker.sv]
// Checker of bus and interrupt request relations at the clock timer ports.
`timescale 1ns/100ps
module lfct_checker
  import lfct_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  cpu_mask_level,
  input wire logic        irq_req,
  input wire logic [1:0]  irq_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Access phases of a control read and of a priority write.
  sequence rd_ctrl; psel && penable && !pwrite && paddr == LFCT_CTRL_ADDR; endsequence
  sequence wr_prio; psel && penable && pwrite && pstrb[0] && paddr == LFCT_PRIO_ADDR; endsequence
  a_ready_always: assert property (pready) else $error("pready low");
  a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  a_slverr_access: assert property (pslverr |-> psel && penable) else $error("stray slverr");
  a_clear_reads_zero: assert property (rd_ctrl |-> !prdata[LFCT_CLEAR_BIT])
    else $error("clear bit read as one");
  a_prio_write_level: assert property (wr_prio |=> irq_level == $past(pwdata[1:0]))
    else $error("priority not taken");
  a_irq_above_mask: assert property (irq_req |-> irq_level > cpu_mask_level)
    else $error("request at or below mask");
  a_zero_prio_quiet: assert property (irq_level == 2'h0 |-> !irq_req)
    else $error("request at level zero");
  a_reset_quiet: assert property ($rose(rst_n) |-> irq_level == 2'h0 && !irq_req)
    else $error("interrupt state after reset");
endmodule

// [tb/lfct_cpu_model.sv]
// Behavioural model of the CPU interrupt side: mask level and request acceptance.
`timescale 1ns/100ps
module lfct_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] mask_req,
  input  wire logic       irq_req,
  input  wire logic [1:0] irq_level,
  output logic      [1:0] cpu_mask_level,
  output logic            taken
);
  // The mask follows the bench; a request is taken only above the mask.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_mask_level <= 2'h0;
      taken          <= 1'b0;
    end else begin
      cpu_mask_level <= mask_req;
      taken          <= irq_req && (irq_level > cpu_mask_level);
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the clock timer registers and interrupt request.
`timescale 1ns/100ps
module tb_top;
  import lfct_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_req, taken, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [1:0]  mask_req, cpu_mask_level, irq_level;
  logic [23:0] irq_vector;
  logic [7:0]  rb, v;
  logic [15:0] addrs [5] = '{LFCT_PRIO_ADDR, LFCT_EN_ADDR, LFCT_CAUSE_ADDR,
                             LFCT_CTRL_ADDR, LFCT_COUNT_ADDR};
  int          errors, total_checks, n;

  // A short tick lets the counter wrap within the run.
  lfct_timer #(.TICK_CYCLES(8)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_mask_level(cpu_mask_level), .irq_req(irq_req),
    .irq_level(irq_level), .irq_vector(irq_vector));
  lfct_cpu_model cpu_u (.clk(clk), .rst_n(rst_n), .mask_req(mask_req), .irq_req(irq_req),
    .irq_level(irq_level), .cpu_mask_level(cpu_mask_level), .taken(taken));

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one byte result and reports a mismatch.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB byte transfer on its lane; read data and error are taken at the ready edge.
  task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= 32'(d) << (8 * a[1:0]);
    pstrb   <= 4'h1 << a[1:0];
    psel    <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rb  = 8'(prdata >> (8 * a[1:0]));
    err = pslverr;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Main sequence: reset values, random register traffic, then corner cases.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mask_req = 2'h0;
    errors = 0;
    total_checks = 0;
    v = 8'($urandom(32'h01d7acca));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (addrs[i]) begin
      xfer(addrs[i], 1'b0, 8'h00);
      chk("reset value", 8'h00, rb);
    end
    repeat (8) begin
      v = 8'($urandom);
      mask_req <= v[5:4];
      xfer(LFCT_EN_ADDR, 1'b1, v);
      xfer(LFCT_EN_ADDR, 1'b0, 8'h00);
      chk("enables", v & 8'h0f, rb);
      xfer(LFCT_PRIO_ADDR, 1'b1, v);
      xfer(LFCT_PRIO_ADDR, 1'b0, 8'h00);
      chk("priority", v & 8'h03, rb);
      chk("irq level", v & 8'h03, {6'h0, irq_level});
      chk("irq request", 8'h00, {7'h0, irq_req});
      xfer(LFCT_COUNT_ADDR, 1'b1, v);
      xfer(LFCT_COUNT_ADDR, 1'b0, 8'h00);
      chk("count", 8'h00, rb);
    end
    xfer(LFCT_CTRL_ADDR, 1'b1, 8'h02);
    xfer(LFCT_CTRL_ADDR, 1'b0, 8'h00);
    chk("clear bit", 8'h00, rb);
    xfer(LFCT_COUNT_ADDR, 1'b0, 8'h00);
    chk("cleared count", 8'h00, rb);
    xfer(LFCT_CAUSE_ADDR, 1'b1, 8'h0f);
    xfer(LFCT_CAUSE_ADDR, 1'b0, 8'h00);
    chk("causes", 8'h00, rb);
    chk("idle vector", LFCT_VEC_1HZ[7:0], irq_vector[7:0]);
    // Run long enough for the top stage to wrap, then stop and inspect causes.
    mask_req <= 2'h0;
    xfer(LFCT_EN_ADDR, 1'b1, 8'h0f);
    xfer(LFCT_PRIO_ADDR, 1'b1, 8'h03);
    xfer(LFCT_CTRL_ADDR, 1'b1, 8'h01);
    xfer(LFCT_CTRL_ADDR, 1'b0, 8'h00);
    chk("run bit", 8'h01, rb);
    repeat (2200) @(posedge clk);
    xfer(LFCT_CTRL_ADDR, 1'b1, 8'h00);
    n = 0;
    do begin
      xfer(LFCT_CTRL_ADDR, 1'b0, 8'h00);
      n++;
    end while (rb !== 8'h00 && n < 50);
    chk("run stopped", 8'h00, rb);
    xfer(LFCT_COUNT_ADDR, 1'b0, 8'h00);
    v = rb;
    repeat (100) @(posedge clk);
    xfer(LFCT_COUNT_ADDR, 1'b0, 8'h00);
    chk("held count", v, rb);
    xfer(LFCT_CAUSE_ADDR, 1'b0, 8'h00);
    chk("all causes", 8'h0f, rb);
    chk("irq pending", 8'h01, {7'h0, irq_req});
    chk("vector 32", LFCT_VEC_32HZ[7:0], irq_vector[7:0]);
    xfer(LFCT_CAUSE_ADDR, 1'b1, 8'h08);
    xfer(LFCT_CAUSE_ADDR, 1'b0, 8'h00);
    chk("one cleared", 8'h07, rb);
    chk("vector 8", LFCT_VEC_8HZ[7:0], irq_vector[7:0]);
    xfer(LFCT_CAUSE_ADDR, 1'b1, 8'h04);
    chk("vector 2", LFCT_VEC_2HZ[7:0], irq_vector[7:0]);
    xfer(LFCT_CAUSE_ADDR, 1'b1, 8'h00);
    xfer(LFCT_CAUSE_ADDR, 1'b0, 8'h00);
    chk("zero write", 8'h03, rb);
    mask_req <= 2'h3;
    xfer(LFCT_CAUSE_ADDR, 1'b0, 8'h00);
    chk("masked irq", 8'h00, {7'h0, irq_req});
    xfer(LFCT_CTRL_ADDR, 1'b1, 8'h02);
    repeat (40) @(posedge clk);
    xfer(LFCT_COUNT_ADDR, 1'b0, 8'h00);
    chk("stopped clear", 8'h00, rb);
    xfer(16'hff30, 1'b0, 8'h00);
    chk("unmapped error", 8'h01, {7'h0, err});
    chk("taken request", 8'h00, {7'h0, taken});
    print_verdict();
  end
endmodule

bind lfct_timer lfct_checker chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_mask_level(cpu_mask_level),
  .irq_req(irq_req), .irq_level(irq_level));
